// >>> pkg/synth_update_pkg.sv
// Shared constants, field layouts and carriers for the synthesizer update block
package synth_update_pkg;

  // Serial word layout: 24 bits, register select in the low three bits
  localparam int SERIAL_WORD_W    = 24;
  localparam int SEL_LSB          = 0;
  localparam int SEL_W            = 3;
  localparam logic [2:0] SEL_CHANNEL = 3'h0;
  localparam logic [2:0] SEL_MODDIV  = 3'h1;
  localparam logic [2:0] SEL_SEED    = 3'h2;

  // Field positions inside the serial words
  localparam int INT_LSB          = 15;
  localparam int INT_W            = 8;
  localparam int NUMERATOR_VALUE_LSB         = 3;
  localparam int NUMERATOR_VALUE_W           = 12;
  localparam int MOD_LSB          = 3;
  localparam int REFDIV_LSB       = 15;
  localparam int REFDIV_W         = 4;
  localparam int BOOST_BIT        = 23;
  localparam int SEED_LSB         = 3;

  // Register offsets on the bus (byte addresses)
  localparam logic [7:0] OFS_PUMP_TIMER   = 8'h00;
  localparam logic [7:0] OFS_PAIR_TIMER   = 8'h04;
  localparam logic [7:0] OFS_THIRD_TIMER  = 8'h08;
  localparam logic [7:0] OFS_STATUS       = 8'h0c;
  localparam logic [7:0] OFS_ACT_CHANNEL  = 8'h10;
  localparam logic [7:0] OFS_ACT_MODDIV   = 8'h14;
  localparam logic [7:0] OFS_ACT_SEED     = 8'h18;

  // Timer widths and reset values, counted in reference (PFD) cycles
  localparam int TIMER_W                  = 10;
  localparam logic [9:0] PUMP_TIMER_RST   = 10'h01c;
  localparam logic [9:0] PAIR_TIMER_RST   = 10'h023;
  localparam logic [9:0] THIRD_TIMER_RST  = 10'h023;

  // Reset values of shadow and active settings
  localparam logic [11:0] MOD_RST         = 12'h041;
  localparam logic [3:0]  REFDIV_RST      = 4'h1;

  // Classic single-cycle bus request
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } wbReq_s;

  // Settings that drive the divider, modulator and pump
  typedef struct packed {
    logic [INT_W-1:0]    intValue;
    logic [NUMERATOR_VALUE_W-1:0]   numeratorValue;
    logic [NUMERATOR_VALUE_W-1:0]   denominatorValue;
    logic [REFDIV_W-1:0] refDivide;
    logic                pumpBoostBit;
    logic [NUMERATOR_VALUE_W-1:0]   seedOffset;
  } activeSet_s;

  // Fast-lock sequence states
  typedef enum logic [1:0] {
    LOCK_IDLE,
    LOCK_PENDING,
    LOCK_WIDE,
    LOCK_NARROW
  } lockState_e;

endpackage

// >>> verilog/pin_edge_sync.sv
// Three-stage pin synchroniser with agreed level and rising-edge pulse
`timescale 1ns/100ps
module pin_edge_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clock,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] pins,
  output logic      [WIDTH-1:0] level,
  output logic      [WIDTH-1:0] rise
);

  logic [WIDTH-1:0] stage1_r;
  logic [WIDTH-1:0] stage2_r;
  logic [WIDTH-1:0] stage3_r;
  logic [WIDTH-1:0] level_r;
  logic [WIDTH-1:0] agree;

  if (WIDTH < 1) begin : gWidthCheck
    $error("pin_edge_sync needs at least one pin");
  end

  // Stage one feeds stage two only, to keep metastability contained
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      stage1_r <= '0;
      stage2_r <= '0;
      stage3_r <= '0;
      level_r  <= '0;
    end else begin
      stage1_r <= pins;
      stage2_r <= stage1_r;
      stage3_r <= stage2_r;
      level_r  <= (agree & stage2_r) | (~agree & level_r);
    end
  end

  // A change counts only once stages two and three agree
  assign agree = ~(stage2_r ^ stage3_r);
  assign rise  = agree & stage2_r & ~level_r;
  assign level = level_r;

endmodule // pin_edge_sync

// >>> verilog/fraction_accumulator.sv
// Digital fractional accumulator, one step per reference cycle
`timescale 1ns/100ps
module fraction_accumulator #(
  parameter int NUMERATOR_VALUE_W = 12
) (
  input  wire logic              clock,
  input  wire logic              rst_n,
  input  wire logic              seedLoad,
  input  wire logic [NUMERATOR_VALUE_W-1:0] seedValue,
  input  wire logic              step,
  input  wire logic [NUMERATOR_VALUE_W-1:0] numerator,
  input  wire logic [NUMERATOR_VALUE_W-1:0] denominator,
  output logic                   carry,
  output logic      [NUMERATOR_VALUE_W-1:0] residue
);

  logic [NUMERATOR_VALUE_W-1:0] acc_r;
  logic [NUMERATOR_VALUE_W-1:0] acc_nxt;
  logic              carry_r;
  logic              carry_nxt;
  logic [NUMERATOR_VALUE_W:0]   sum;
  logic              wrap;

  if (NUMERATOR_VALUE_W < 2) begin : gFracCheck
    $error("fraction_accumulator needs NUMERATOR_VALUE_W of at least 2");
  end

  // Sum and wrap against the modulus; residue is the quantisation error
  assign sum       = {1'b0, acc_r} + {1'b0, numerator};
  assign wrap      = sum >= {1'b0, denominator};
  assign acc_nxt   = wrap ? NUMERATOR_VALUE_W'(sum - {1'b0, denominator}) : sum[NUMERATOR_VALUE_W-1:0];
  assign carry_nxt = wrap;

  // Seed wins over a step in the same cycle so each update starts clean
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      acc_r   <= '0;
      carry_r <= 1'b0;
    end else if (seedLoad) begin
      acc_r   <= seedValue; // RULE_05
      carry_r <= 1'b0;
    end else if (step) begin
      acc_r   <= acc_nxt; // RULE_04
      carry_r <= carry_nxt;
    end
  end

  assign carry   = carry_r;
  assign residue = acc_r;

endmodule // fraction_accumulator

// >>> verilog/channel_update_ctrl.sv
// Serial programming, double-buffered update and fast-lock timing control
`timescale 1ns/100ps

// Summary of operation
// RULE_01 - Every channel-word write starts a fresh fast-lock sequence
// RULE_02 - Sequence reduces pump current and opens loop-filter switches to narrow bandwidth
// RULE_03 - Separate programmable timers pick the reference cycle for each event
// RULE_04 - Modulator is digital and steps once per reference cycle
// RULE_05 - Channel-word write seeds the modulator from the phase-seed word
// RULE_06 - Seed word is double buffered; host writes seed before channel word
// RULE_07 - Modulus/divider word changes reference divider and modulus together
// RULE_08 - Bit 23 of modulus/divider word boosts pump current, double buffered
// RULE_09 - Modulus/divider writes stay in shadow until next channel-word write
// RULE_10 - Host writes channel word last when programming a frequency
// RULE_11 - Host may preload all words and delay the channel latch edge
// RULE_12 - Shifting or latching shadow words never disturbs active settings
// RULE_13 - Channel latch moves all shadow values to active together
// RULE_14 - Twenty-four bits shift on rising clock; latch rise loads addressed word
// RULE_15 - Divider takes new values on first reference cycle after latch
// RULE_16 - Seed sets output phase in steps of a full turn over modulus
module channel_update_ctrl
  import synth_update_pkg::*;
#(
  parameter int TIMER_WIDTH = synth_update_pkg::TIMER_W
) (
  input  wire logic                        clock,
  input  wire logic                        rst_n,
  input  wire synth_update_pkg::wbReq_s    wbReq,
  output logic                             wbAck,
  output logic      [31:0]                 wbDatOut,
  input  wire logic                        serialClockPin,
  input  wire logic                        serialDataPin,
  input  wire logic                        latchStrobePin,
  input  wire logic                        referenceInputPin,
  output synth_update_pkg::activeSet_s     activeSet,
  output logic      [synth_update_pkg::INT_W:0] dividerRatio,
  output logic                             pfdTick,
  output logic                             pumpCurrentReduced,
  output logic                             filterSwitchPairOpen,
  output logic                             filterSwitchThirdOpen,
  output logic                             fastLockBusy
);
  import synth_update_pkg::*;

  if (TIMER_WIDTH < 2 || TIMER_WIDTH > 16) begin : gTimerCheck
    $error("channel_update_ctrl supports TIMER_WIDTH from 2 to 16");
  end

  // Merge a bus write into a register through its byte enables
  function automatic logic [31:0] laneMerge(input logic [31:0] oldVal, input logic [31:0] newVal,
                                            input logic [3:0] sel);
    logic [31:0] mask;
    mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    return (newVal & mask) | (oldVal & ~mask);
  endfunction

  // ---------------------------------------------------------------- pins
  logic [3:0] pinLevel;
  logic [3:0] pinRise;
  logic       serialClockRise;
  logic       serialDataLevel;
  logic       latchRise;
  logic       referenceRise;

  pin_edge_sync #(
    .WIDTH (4)
  ) uPinSync (
    .clock (clock),
    .rst_n (rst_n),
    .pins  ({referenceInputPin, latchStrobePin, serialDataPin, serialClockPin}),
    .level (pinLevel),
    .rise  (pinRise)
  );

  assign serialClockRise = pinRise[0];
  assign serialDataLevel = pinLevel[1];
  assign latchRise       = pinRise[2];
  assign referenceRise   = pinRise[3];

  // ---------------------------------------------------------- serial shift
  logic [SERIAL_WORD_W-1:0] shift_r;
  logic [SERIAL_WORD_W-1:0] shift_nxt;

  // Only the last 24 bits before the latch count; extra leading bits fall off
  assign shift_nxt = {shift_r[SERIAL_WORD_W-2:0], serialDataLevel};

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      shift_r <= '0;
    end else if (serialClockRise) begin
      shift_r <= shift_nxt; // RULE_14
    end
  end

  // Latch decode on the agreed rising edge of the strobe
  logic [SEL_W-1:0] wordSelect;
  logic             loadChannel;
  logic             loadModDiv;
  logic             loadSeed;

  assign wordSelect  = shift_r[SEL_LSB +: SEL_W];
  assign loadChannel = latchRise && (wordSelect == SEL_CHANNEL); // RULE_14
  assign loadModDiv  = latchRise && (wordSelect == SEL_MODDIV);
  assign loadSeed    = latchRise && (wordSelect == SEL_SEED);

  // ------------------------------------------------------- shadow storage
  logic [NUMERATOR_VALUE_W-1:0]   shadowMod_r;
  logic [REFDIV_W-1:0] shadowRefDiv_r;
  logic                shadowBoost_r;
  logic [NUMERATOR_VALUE_W-1:0]   shadowSeed_r;
  logic [INT_W-1:0]    pendingInt_r;
  logic [NUMERATOR_VALUE_W-1:0]   pendingFrac_r;

  // Shadow words touch nothing active, so shifting can run mid-burst
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      shadowMod_r    <= MOD_RST;
      shadowRefDiv_r <= REFDIV_RST;
      shadowBoost_r  <= 1'b0;
      shadowSeed_r   <= '0;
      pendingInt_r   <= '0;
      pendingFrac_r  <= '0;
    end else begin
      if (loadModDiv) begin
        shadowMod_r    <= shift_r[MOD_LSB +: NUMERATOR_VALUE_W]; // RULE_09 RULE_12
        shadowRefDiv_r <= shift_r[REFDIV_LSB +: REFDIV_W]; // RULE_07
        shadowBoost_r  <= shift_r[BOOST_BIT]; // RULE_08
      end
      if (loadSeed) begin
        shadowSeed_r   <= shift_r[SEED_LSB +: NUMERATOR_VALUE_W]; // RULE_06 RULE_12
      end
      if (loadChannel) begin
        pendingInt_r   <= shift_r[INT_LSB +: INT_W];
        pendingFrac_r  <= shift_r[NUMERATOR_VALUE_LSB +: NUMERATOR_VALUE_W];
      end
    end
  end

  // ------------------------------------------------------ reference divider
  logic [REFDIV_W-1:0] refCount_r;
  logic [REFDIV_W-1:0] refCount_nxt;
  logic [REFDIV_W-1:0] refLast;
  logic                pfdStep;
  activeSet_s          active_r;

  // A ratio of zero is served as one, so the reference never stalls
  assign refLast      = (active_r.refDivide == '0) ? '0 : REFDIV_W'(active_r.refDivide - 1'b1);
  assign pfdStep      = referenceRise && (refCount_r == refLast);
  assign refCount_nxt = pfdStep ? '0 : REFDIV_W'(refCount_r + 1'b1);

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      refCount_r <= '0;
    end else if (referenceRise) begin
      refCount_r <= refCount_nxt;
    end
  end

  // ---------------------------------------------------- fast-lock sequencer
  lockState_e             state_r;
  lockState_e             state_nxt;
  logic [TIMER_WIDTH-1:0] pumpTimer_r;
  logic [TIMER_WIDTH-1:0] pairTimer_r;
  logic [TIMER_WIDTH-1:0] thirdTimer_r;
  logic [TIMER_WIDTH-1:0] cycleCount_r;
  logic                   applyUpdate;
  logic                   pumpDue;
  logic                   pairDue;
  logic                   thirdDue;
  logic                   allDue;

  // The update lands on the first reference cycle after the latch
  assign applyUpdate = (state_r == LOCK_PENDING) && pfdStep && !loadChannel; // RULE_15
  assign pumpDue     = cycleCount_r >= pumpTimer_r; // RULE_03
  assign pairDue     = cycleCount_r >= pairTimer_r; // RULE_03
  assign thirdDue    = cycleCount_r >= thirdTimer_r; // RULE_03
  assign allDue      = pumpDue && pairDue && thirdDue;

  // Next state; a new channel latch restarts from any state
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      LOCK_IDLE: begin
        state_nxt = state_r;
      end
      LOCK_PENDING: begin
        if (applyUpdate) begin
          state_nxt = LOCK_WIDE;
        end
      end
      LOCK_WIDE: begin
        if (allDue) begin
          state_nxt = LOCK_NARROW;
        end
      end
      LOCK_NARROW: begin
        state_nxt = state_r;
      end
      default: begin
        state_nxt = LOCK_IDLE;
      end
    endcase
    if (loadChannel) begin
      state_nxt = LOCK_PENDING; // RULE_01
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state_r <= LOCK_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Reference cycles since the update; saturates so late timers still fire
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cycleCount_r <= '0;
    end else if (applyUpdate) begin
      cycleCount_r <= '0;
    end else if (state_r == LOCK_WIDE && pfdStep && !allDue) begin
      cycleCount_r <= TIMER_WIDTH'(cycleCount_r + 1'b1);
    end
  end

  // Bandwidth controls: wide from the update until each timer expires
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pumpCurrentReduced    <= 1'b0;
      filterSwitchPairOpen  <= 1'b0;
      filterSwitchThirdOpen <= 1'b0;
    end else if (applyUpdate) begin
      pumpCurrentReduced    <= 1'b0;
      filterSwitchPairOpen  <= 1'b0;
      filterSwitchThirdOpen <= 1'b0;
    end else if (state_r == LOCK_WIDE) begin
      pumpCurrentReduced    <= pumpDue; // RULE_02
      filterSwitchPairOpen  <= pairDue; // RULE_02
      filterSwitchThirdOpen <= thirdDue; // RULE_02
    end
  end

  assign fastLockBusy = (state_r == LOCK_PENDING) || (state_r == LOCK_WIDE);

  // --------------------------------------------------------- active copies
  // All shadow values move in one step with the channel values
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      active_r.intValue         <= '0;
      active_r.numeratorValue   <= '0;
      active_r.denominatorValue <= MOD_RST;
      active_r.refDivide        <= REFDIV_RST;
      active_r.pumpBoostBit     <= 1'b0;
      active_r.seedOffset       <= '0;
    end else if (applyUpdate) begin
      active_r.intValue         <= pendingInt_r; // RULE_15
      active_r.numeratorValue   <= pendingFrac_r; // RULE_15
      active_r.denominatorValue <= shadowMod_r; // RULE_13 RULE_09
      active_r.refDivide        <= shadowRefDiv_r; // RULE_07 RULE_13
      active_r.pumpBoostBit     <= shadowBoost_r; // RULE_08 RULE_13
      active_r.seedOffset       <= shadowSeed_r; // RULE_06 RULE_13
    end
  end

  assign activeSet = active_r;
  assign pfdTick   = pfdStep;

  // -------------------------------------------------------------- modulator
  // Seeding offsets the fraction phase by seed/modulus of a cycle
  logic              modCarry;
  logic [NUMERATOR_VALUE_W-1:0] modResidue;

  fraction_accumulator #(
    .NUMERATOR_VALUE_W (NUMERATOR_VALUE_W)
  ) uModulator (
    .clock       (clock),
    .rst_n       (rst_n),
    .seedLoad    (applyUpdate),
    .seedValue   (shadowSeed_r),
    .step        (pfdStep),
    .numerator   (active_r.numeratorValue),
    .denominator (active_r.denominatorValue),
    .carry       (modCarry),
    .residue     (modResidue)
  ); // RULE_05 RULE_16

  assign dividerRatio = {1'b0, active_r.intValue} + {{INT_W{1'b0}}, modCarry}; // RULE_04

  // ------------------------------------------------------------ bus slave
  logic        busHit;
  logic        busWrite;
  logic [7:0]  wordAddr;
  logic [31:0] readMux;
  logic [31:0] pumpMerged;
  logic [31:0] pairMerged;
  logic [31:0] thirdMerged;
  logic        ack_r;

  assign busHit      = wbReq.cyc && wbReq.stb && !ack_r;
  assign busWrite    = busHit && wbReq.we;
  assign wordAddr    = {wbReq.adr[7:2], 2'b00};
  assign pumpMerged  = laneMerge(32'(pumpTimer_r), wbReq.dat, wbReq.sel);
  assign pairMerged  = laneMerge(32'(pairTimer_r), wbReq.dat, wbReq.sel);
  assign thirdMerged = laneMerge(32'(thirdTimer_r), wbReq.dat, wbReq.sel);

  // Read selection; unmapped offsets read zero and still acknowledge
  always_comb begin
    case (wordAddr)
      OFS_PUMP_TIMER:  readMux = 32'(pumpTimer_r);
      OFS_PAIR_TIMER:  readMux = 32'(pairTimer_r);
      OFS_THIRD_TIMER: readMux = 32'(thirdTimer_r);
      OFS_STATUS:      readMux = {26'h0, fastLockBusy, filterSwitchThirdOpen, filterSwitchPairOpen,
                                  pumpCurrentReduced, state_r};
      OFS_ACT_CHANNEL: readMux = {12'h0, active_r.intValue, active_r.numeratorValue};
      OFS_ACT_MODDIV:  readMux = {8'h0, active_r.pumpBoostBit, 3'h0, active_r.refDivide,
                                  4'h0, active_r.denominatorValue};
      OFS_ACT_SEED:    readMux = {20'h0, active_r.seedOffset};
      default:         readMux = 32'h0;
    endcase
  end

  // Timers are software settings; a change mid-sequence applies at once
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pumpTimer_r  <= TIMER_WIDTH'(PUMP_TIMER_RST);
      pairTimer_r  <= TIMER_WIDTH'(PAIR_TIMER_RST);
      thirdTimer_r <= TIMER_WIDTH'(THIRD_TIMER_RST);
    end else if (busWrite) begin
      if (wordAddr == OFS_PUMP_TIMER) begin
        pumpTimer_r <= pumpMerged[TIMER_WIDTH-1:0]; // RULE_03
      end
      if (wordAddr == OFS_PAIR_TIMER) begin
        pairTimer_r <= pairMerged[TIMER_WIDTH-1:0]; // RULE_03
      end
      if (wordAddr == OFS_THIRD_TIMER) begin
        thirdTimer_r <= thirdMerged[TIMER_WIDTH-1:0]; // RULE_03
      end
    end
  end

  // One-cycle ack, then dropped; data registered alongside it
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ack_r    <= 1'b0;
      wbDatOut <= 32'h0;
    end else begin
      ack_r    <= busHit;
      wbDatOut <= (busHit && !wbReq.we) ? readMux : 32'h0;
    end
  end

  assign wbAck = ack_r;

endmodule // channel_update_ctrl

// >>> testbench/serial_host.sv
// Host-side model driving the three-wire serial programming port
`timescale 1ns/100ps
module serial_host (
  output logic serialClock,
  output logic serialData,
  output logic latchStrobe
);
  // Serial clock stands still low outside frames
  initial begin
    serialClock = 1'b0;
    serialData  = 1'b0;
    latchStrobe = 1'b0;
  end

  // MSB first, data settles half a period before each rising clock edge
  task automatic send(input logic [23:0] word, input int holdNs);
    // Let the last latch pulse stand long enough to be seen before it drops
    #125 latchStrobe = 1'b0;
    for (int i = 23; i >= 0; i--) begin
      serialData = word[i];
      #62.5 serialClock = 1'b1;
      #62.5 serialClock = 1'b0;
    end
    // Released data line shows the inverse, so a stale bit cannot pass
    serialData = ~word[0];
    #(62.5 + holdNs);
    latchStrobe = 1'b1;
  endtask
endmodule // serial_host

// >>> testbench/channel_update_properties.sv
// Concurrent checks on the channel update block ports
`timescale 1ns/100ps
module channel_update_properties
  import synth_update_pkg::*;
(
  input wire logic                         clock,
  input wire logic                         rst_n,
  input wire synth_update_pkg::activeSet_s activeSet,
  input wire logic [INT_W:0]               dividerRatio,
  input wire logic                         pfdTick,
  input wire logic                         pumpCurrentReduced,
  input wire logic                         filterSwitchPairOpen,
  input wire logic                         filterSwitchThirdOpen,
  input wire logic                         fastLockBusy
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);

  // Apply step and the tick that must precede it
  sequence s_apply;
    $changed(activeSet);
  endsequence
  sequence s_after_tick;
    $past(pfdTick) || $past(pfdTick, 2);
  endsequence

  property p_active_on_tick;
    s_apply |-> $past(pfdTick);
  endproperty
  property p_apply_starts_lock;
    s_apply |-> fastLockBusy;
  endproperty
  property p_pump_on_tick;
    $rose(pumpCurrentReduced) |-> s_after_tick;
  endproperty
  property p_pair_on_tick;
    $rose(filterSwitchPairOpen) |-> s_after_tick;
  endproperty
  property p_third_on_tick;
    $rose(filterSwitchThirdOpen) |-> s_after_tick;
  endproperty
  property p_controls_clear;
    $fell(pumpCurrentReduced) || $fell(filterSwitchPairOpen) || $fell(filterSwitchThirdOpen) |-> $past(pfdTick);
  endproperty
  property p_divider_ratio;
    (dividerRatio == {1'b0, activeSet.intValue}) || (dividerRatio == {1'b0, activeSet.intValue} + 9'h001);
  endproperty
  property p_pfd_pulse;
    pfdTick |=> !pfdTick;
  endproperty

  a_active_on_tick: assert property (p_active_on_tick)
    else $error("active settings changed off a reference tick");
  a_apply_starts_lock: assert property (p_apply_starts_lock)
    else $error("apply without fast-lock busy");
  a_pump_on_tick: assert property (p_pump_on_tick)
    else $error("pump reduction off a reference tick");
  a_pair_on_tick: assert property (p_pair_on_tick)
    else $error("pair switch opened off a reference tick");
  a_third_on_tick: assert property (p_third_on_tick)
    else $error("third switch opened off a reference tick");
  a_controls_clear: assert property (p_controls_clear)
    else $error("controls cleared without an apply tick");
  a_divider_ratio: assert property (p_divider_ratio)
    else $error("divider ratio not integer plus carry");
  a_pfd_pulse: assert property (p_pfd_pulse)
    else $error("reference tick longer than one cycle");
endmodule // channel_update_properties

bind channel_update_ctrl channel_update_properties channel_update_properties_inst (
  .clock(clock), .rst_n(rst_n), .activeSet(activeSet), .dividerRatio(dividerRatio), .pfdTick(pfdTick),
  .pumpCurrentReduced(pumpCurrentReduced), .filterSwitchPairOpen(filterSwitchPairOpen),
  .filterSwitchThirdOpen(filterSwitchThirdOpen), .fastLockBusy(fastLockBusy));

// >>> testbench/double_buffered_channel_update_test.sv
// Self-checking bench for the double-buffered channel update block
`timescale 1ns/100ps
module double_buffered_channel_update_test;
  import synth_update_pkg::*;
  logic           clock;
  logic           rst_n = 1'b0;
  wbReq_s         wbReq = '0;
  logic           wbAck;
  logic [31:0]    wbDatOut;
  logic           serialClock, serialData, latchStrobe, refPin;
  activeSet_s     activeSet;
  logic [INT_W:0] dividerRatio;
  logic           pfdTick, pumpCurrentReduced, filterSwitchPairOpen, filterSwitchThirdOpen, fastLockBusy;
  logic [32:0]    expQ[$];
  logic [32:0]    note;
  logic [31:0]    prevModdiv, prevSeed;
  int             fails = 0;
  int             tests_run = 0;
  int             seed = 95871;

  channel_update_ctrl channel_update_ctrl_inst (.clock(clock), .rst_n(rst_n), .wbReq(wbReq), .wbAck(wbAck),
    .wbDatOut(wbDatOut), .serialClockPin(serialClock), .serialDataPin(serialData), .latchStrobePin(latchStrobe),
    .referenceInputPin(refPin), .activeSet(activeSet), .dividerRatio(dividerRatio), .pfdTick(pfdTick),
    .pumpCurrentReduced(pumpCurrentReduced), .filterSwitchPairOpen(filterSwitchPairOpen),
    .filterSwitchThirdOpen(filterSwitchThirdOpen), .fastLockBusy(fastLockBusy));
  serial_host serial_host_inst (.serialClock(serialClock), .serialData(serialData), .latchStrobe(latchStrobe));

  // Clocks: reference half period unrelated to the system clock
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  initial begin
    refPin = 1'b0;
    #3;
    forever #63 refPin = ~refPin;
  end

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run;
    $display("Comparisons %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // One classic cycle; reads note the expected data for the monitor
  task automatic bus(input logic we, input logic [7:0] adr, input logic [31:0] dat, input logic [3:0] sel);
    int n;
    n = 0;
    @(posedge clock);
    expQ.push_back({~we, dat});
    wbReq <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: sel, dat: we ? dat : 32'h0};
    @(posedge clock);
    while (wbAck !== 1'b1 && n < 50) begin
      @(posedge clock);
      n++;
    end
    if (n == 50) fails++;
    wbReq <= '0;
  endtask

  // Each ack retires the oldest note
  always @(posedge clock) begin
    if (wbAck === 1'b1) begin
      note = expQ.pop_front();
      if (note[32]) check(wbDatOut, note[31:0]);
    end
  end

  // Shadow words, ignored select, then channel word; measure the fast-lock steps
  task automatic program_round(input int r);
    logic [9:0]  tp, ta, tc;
    logic [11:0] sd, md, fr;
    logic [7:0]  iv;
    int          n, k, cp, ca, cc;
    tp = 10'(2 + ($random(seed) & 7));
    ta = tp + 10'(1 + ($random(seed) & 3));
    tc = ta + 10'($random(seed) & 3);
    sd = 12'($random(seed));
    md = 12'h040 | 12'($random(seed) & 63);
    fr = 12'($unsigned($random(seed)) % md);
    iv = 8'h80 | 8'(r << 6) | 8'($random(seed) & 63);
    bus(1'b1, OFS_PUMP_TIMER, 32'(tp), 4'hf);
    bus(1'b1, OFS_PAIR_TIMER, 32'(ta), 4'hf);
    bus(1'b1, OFS_THIRD_TIMER, 32'(tc), 4'hf);
    bus(1'b0, OFS_PAIR_TIMER, 32'(ta), 4'hf);
    serial_host_inst.send({9'h000, sd, SEL_SEED}, 0);
    serial_host_inst.send({~r[0], 4'h0, 4'(r + 1), md, SEL_MODDIV}, 0);
    serial_host_inst.send({21'($random(seed)), 3'h3}, 0);
    bus(1'b0, OFS_ACT_MODDIV, prevModdiv, 4'hf);
    bus(1'b0, OFS_ACT_SEED, prevSeed, 4'hf);
    serial_host_inst.send({1'b0, iv, fr, SEL_CHANNEL}, 400 * r);
    n = 0;
    while (activeSet.intValue !== iv && n < 3000) begin
      @(posedge clock); #1;
      n++;
    end
    k = 0; cp = 0; ca = 0; cc = 0;
    while (cc == 0 && n < 8000) begin
      if (pfdTick === 1'b1) k++;
      @(posedge clock); #1;
      n++;
      if (pumpCurrentReduced === 1'b1 && cp == 0) cp = k;
      if (filterSwitchPairOpen === 1'b1 && ca == 0) ca = k;
      if (filterSwitchThirdOpen === 1'b1 && cc == 0) cc = k;
    end
    check(64'(cp), 64'(tp));
    check(64'(ca), 64'(ta));
    check(64'(cc), 64'(tc));
    check(64'(activeSet), 64'({iv, fr, md, 4'(r + 1), ~r[0], sd}));
    bus(1'b0, OFS_STATUS, 32'h0000001f, 4'hf);
    prevModdiv = {8'h00, ~r[0], 3'h0, 4'(r + 1), 4'h0, md};
    prevSeed = 32'(sd);
  endtask

  // Watchdog several times the expected run length
  initial begin
    #200000;
    fails++;
    $display("ERROR %0t: watchdog expired", $time);
    complete_run;
  end

  // Reset, reset values, refused writes, then two programming rounds
  initial begin
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    repeat (5) @(posedge clock);
    bus(1'b0, OFS_PUMP_TIMER, 32'(PUMP_TIMER_RST), 4'hf);
    bus(1'b0, OFS_THIRD_TIMER, 32'(THIRD_TIMER_RST), 4'hf);
    bus(1'b0, OFS_STATUS, 32'h0, 4'hf);
    bus(1'b0, OFS_ACT_MODDIV, (32'(REFDIV_RST) << 16) | 32'(MOD_RST), 4'hf);
    bus(1'b0, 8'h20, 32'h0, 4'hf);
    bus(1'b1, OFS_PAIR_TIMER, 32'h000003ff, 4'h0);
    bus(1'b0, OFS_PAIR_TIMER, 32'(PAIR_TIMER_RST), 4'hf);
    bus(1'b1, OFS_ACT_CHANNEL, 32'hffffffff, 4'hf);
    bus(1'b0, OFS_ACT_CHANNEL, 32'h0, 4'hf);
    prevModdiv = (32'(REFDIV_RST) << 16) | 32'(MOD_RST);
    prevSeed = 32'h0;
    for (int r = 0; r < 2; r++) begin
      program_round(r);
    end
    repeat (4) @(posedge clock);
    complete_run;
  end
endmodule // double_buffered_channel_update_test
